// ---- bench/pgd_plane_mem_model.sv ----
// four-plane display memory model facing the datapath
`timescale 1ns/100ps
module pgd_plane_mem_model (
  input wire logic clk_in,
  input wire pgd_pkg::pgd_plane_req_t req_in,
  output logic [31:0] rd_data_out
);
  logic [31:0] mem [logic [15:0]];
  logic [31:0] cnt = 32'h0;
  logic [31:0] t;
  // unwritten words read as an address-derived pattern
  function automatic logic [31:0] word(input logic [15:0] a);
    return mem.exists(a) ? mem[a] : {~a, a};
  endfunction
  // outside a read the lines carry a changing pattern
  always @* rd_data_out = req_in.rd ? word(req_in.addr) : cnt;
  always @(posedge clk_in) begin
    cnt <= cnt + 32'h9E3779B9;
    if (req_in.wr) begin
      t = word(req_in.addr);
      for (int p = 0; p < 4; p++) begin
        if (req_in.en[p]) t[p*8 +: 8] = req_in.data[p*8 +: 8];
      end
      mem[req_in.addr] = t;
    end
  end
endmodule // pgd_plane_mem_model

// ---- bench/testbench.sv ----
// self-checking bench of the planar graphics datapath
`timescale 1ns/100ps
module testbench;
  logic clk_in = 0, srst_in = 1, io_wr = 0, io_rd = 0, mem_wr = 0;
  logic mem_rd = 0, cf = 0, io_rvalid, ext_wr, mem_rvalid, upper, gfx;
  logic [15:0] io_addr = 16'h0;
  logic [7:0] io_wdata = 8'h0, ext_rdata = 8'h0, mem_wdata = 8'h0;
  logic [7:0] io_rdata, ext_wdata, mem_rdata, d;
  logic [19:0] mem_addr = 20'h0, a;
  logic [3:0] we = 4'h0, ext_index;
  logic [31:0] prd, lat = 32'h0;
  pgd_pkg::pgd_plane_req_t req;
  pgd_pkg::pgd_load_t load_mode;
  logic [7:0] rg [0:8], r8 [0:8];
  logic [7:0] wm [0:8] = '{8'h0F, 8'h0F, 8'h0F, 8'h1F, 8'h03, 8'h7B,
                           8'h0F, 8'h0F, 8'hFF};
  logic [19:0] w_in [0:3] = '{20'hB1234, 20'hA1234, 20'hB1234, 20'hB9234};
  logic [19:0] w_out [0:3] = '{20'hC1234, 20'hB1234, 20'hB9234, 20'hB1234};
  int seed = 32468, n_mismatch = 0, compares = 0, cyc = 0;

  pgd_datapath pgd_datapath_i (.clk_in(clk_in), .srst_in(srst_in),
    .io_wr_in(io_wr), .io_rd_in(io_rd), .io_addr_in(io_addr),
    .io_wdata_in(io_wdata), .io_rdata_out(io_rdata),
    .io_rvalid_out(io_rvalid), .ext_index_out(ext_index),
    .ext_wr_out(ext_wr), .ext_wdata_out(ext_wdata),
    .ext_rdata_in(ext_rdata), .mem_wr_in(mem_wr), .mem_rd_in(mem_rd),
    .mem_addr_in(mem_addr), .mem_wdata_in(mem_wdata),
    .mem_rdata_out(mem_rdata), .mem_rvalid_out(mem_rvalid),
    .chain_four_in(cf), .plane_write_enable_in(we),
    .plane_req_out(req), .plane_rd_data_in(prd),
    .load_mode_out(load_mode), .upper_from_select_out(upper),
    .graphics_mode_out(gfx));
  pgd_plane_mem_model pgd_plane_mem_model_i (.clk_in(clk_in),
    .req_in(req), .rd_data_out(prd));

  initial begin
    forever #2.5 clk_in = ~clk_in;
  end
  // hang guard: whole run needs under two thousand cycles
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end

  // ---------------------------------------------------------------
  // expectations and bus tasks
  // ---------------------------------------------------------------
  function automatic logic oe();
    return rg[6][1] | (rg[5][4] & !cf);
  endfunction
  function automatic logic [3:0] ex_en(input logic a0);
    return oe() ? (a0 ? 4'hA : 4'h5) : 4'hF;
  endfunction
  function automatic logic [7:0] exp_rd(input logic [31:0] l, input logic a0);
    logic [7:0] r;
    logic [1:0] s;
    s = oe() ? {rg[4][1], a0} : rg[4][1:0];
    r = 8'hFF;
    for (int p = 0; p < 4; p++) begin
      if (rg[7][p]) r = r & ~(l[p*8 +: 8] ^ {8{rg[2][p]}});
    end
    return rg[5][3] ? r : l[s*8 +: 8];
  endfunction
  function automatic logic [31:0] exp_wr(input logic [7:0] d,
                                         input logic [31:0] l);
    logic [7:0] rt, v, m, lb;
    logic [31:0] r;
    rt = (d >> rg[3][2:0]) | (d << (4'h8 - {1'h0, rg[3][2:0]}));
    m = (rg[5][1:0] == 2'h3) ? (rt & rg[8]) : rg[8];
    for (int p = 0; p < 4; p++) begin
      lb = l[p*8 +: 8];
      case (rg[5][1:0])
        2'h0: v = rg[1][p] ? {8{rg[0][p]}} : rt;
        2'h2: v = {8{d[p]}};
        default: v = {8{rg[0][p]}};
      endcase
      case (rg[3][4:3])
        2'h1: v = v & lb;
        2'h2: v = v | lb;
        2'h3: v = v ^ lb;
        default: v = v;
      endcase
      r[p*8 +: 8] = (rg[5][1:0] == 2'h1) ? lb : ((v & m) | (lb & ~m));
    end
    return r;
  endfunction
  task automatic cmp(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic io(input logic w, input logic [15:0] ad, input logic [7:0] dd,
                    input logic [7:0] e);
    // idle edge so a strobe is never reassigned in one time step
    @(posedge clk_in);
    #1;
    io_wr = w;
    io_rd = !w;
    io_addr = ad;
    io_wdata = dd;
    @(posedge clk_in);
    #1;
    io_wr = 0;
    io_rd = 0;
    if (!w) cmp("io_rvalid", 1, io_rvalid);
    if (!w) cmp("io_rdata", e, io_rdata);
  endtask
  task automatic wreg(input int i, input logic [7:0] v);
    io(1, 16'h03CE, 8'(i), 8'h0);
    io(1, 16'h03CF, i < 9 ? v & wm[i] : v, 8'h0);
    if (i < 9) rg[i] = v & wm[i];
  endtask
  task automatic rdreg(input int i, input logic [7:0] e);
    io(1, 16'h03CE, 8'(i), 8'h0);
    io(0, 16'h03CF, 8'h0, e);
  endtask
  task automatic mem(input logic w, input logic [19:0] ad,
                     input logic [7:0] dd, input logic hit,
                     input logic [15:0] ea);
    // idle edge between requests, as for the i/o strobes
    @(posedge clk_in);
    #1;
    mem_wr = w;
    mem_rd = !w;
    mem_addr = ad;
    mem_wdata = dd;
    @(posedge clk_in);
    #1;
    mem_wr = 0;
    mem_rd = 0;
    cmp("req_wr", w & hit, req.wr);
    cmp("req_rd", !w & hit, req.rd);
    if (hit && !rg[5][4]) cmp("req_addr", ea, req.addr);
    if (hit) cmp("req_en", w ? we & ex_en(ad[0]) : 4'h0, req.en);
    if (hit & !w) lat = prd;
    if (hit & w) cmp("req_data", exp_wr(dd, lat), req.data);
    if (!w) begin
      @(posedge clk_in);
      #1;
      cmp("mem_rvalid", hit, mem_rvalid);
      if (hit) cmp("mem_rdata", exp_rd(lat, ad[0]), mem_rdata);
    end
  endtask
  task automatic summarize();
    if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_in);
    #1;
    srst_in = 0;
    @(posedge clk_in);
    #1;
    cmp("load_mode", 0, load_mode);
    cmp("upper", 1, upper);
    for (int i = 0; i < 9; i++) rdreg(i, 8'h00);
    for (int i = 0; i < 9; i++) begin
      d = 8'($random(seed));
      wreg(i, d);
      rdreg(i, d & wm[i]);
    end
    // write then read back to back, index still at the bit mask
    @(posedge clk_in);
    #1;
    io_wr = 1;
    io_addr = 16'h03CF;
    io_wdata = 8'h96;
    @(posedge clk_in);
    #1;
    io_wr = 0;
    io_rd = 1;
    @(posedge clk_in);
    #1;
    io_rd = 0;
    cmp("io_rdata", 8'h96, io_rdata);
    io(0, 16'h03CE, 8'h0, 8'h08);
    wreg(9, 8'hC3);
    cmp("ext_wr", 1, ext_wr);
    cmp("ext_wdata", 8'hC3, ext_wdata);
    cmp("ext_index", 4'h9, ext_index);
    ext_rdata = 8'($random(seed));
    io(0, 16'h03CF, 8'h0, ext_rdata);
    for (int it = 0; it < 40; it++) begin
      we = 4'($random(seed));
      for (int i = 0; i < 9; i++) r8[i] = 8'($random(seed));
      r8[3] = {3'h0, 2'(it >> 2), it == 1 ? 3'h7 : r8[3][2:0]};
      r8[5] = {1'h0, r8[5][6], 2'h0,
               it == 5 || (it != 6 && r8[5][3]), 1'h0, 2'(it)};
      r8[6] = {7'h0, r8[6][0]};
      if (it == 0) r8[8] = 8'h00;
      // corner cases: full mask, forced fill enable, no-care compare
      if (it == 14 || it == 16 || it == 32) r8[8] = 8'hFF;
      if (it == 16 || it == 32) r8[1][0] = it == 16;
      if (it == 5) r8[7] = 8'h00;
      if (it == 6) r8[4] = 8'h02;
      for (int i = 0; i < 9; i++) wreg(i, r8[i]);
      a = {4'hA, 16'($random(seed))};
      mem(0, a, 8'h00, 1, a[15:0]);
      mem(1, a, 8'($random(seed)), 1, a[15:0]);
    end
    wreg(5, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wreg(6, {4'h0, 2'(k), 2'h0});
      mem(1, w_in[k], 8'h3C, 1, 16'h1234);
      mem(1, w_out[k], 8'h3C, 0, 16'h1234);
      mem(0, w_out[k], 8'h00, 0, 16'h1234);
    end
    wreg(6, 8'h02);
    wreg(4, 8'h02);
    mem(1, 20'hA0003, 8'h5A, 1, 16'h0002);
    mem(0, 20'hA0003, 8'h00, 1, 16'h0002);
    wreg(6, 8'h00);
    wreg(5, 8'h10);
    cf = 1;
    mem(1, 20'hA0003, 8'hA5, 1, 16'h0003);
    cf = 0;
    mem(1, 20'hA0003, 8'hA5, 1, 16'h0003);
    wreg(5, 8'h40);
    @(posedge clk_in);
    #1;
    cmp("load_mode", 2, load_mode);
    cmp("upper", 0, upper);
    wreg(5, 8'h20);
    wreg(6, 8'h01);
    @(posedge clk_in);
    #1;
    cmp("load_mode", 1, load_mode);
    cmp("graphics", 1, gfx);
    summarize();
  end
endmodule // testbench

// ---- hw/pgd_datapath.sv ----
// host-access write/read datapath of the four-plane graphics unit
`timescale 1ns/100ps
module pgd_datapath (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic io_wr_in,
  input wire logic io_rd_in,
  input wire logic [15:0] io_addr_in,
  input wire logic [7:0] io_wdata_in,
  output logic [7:0] io_rdata_out,
  output logic io_rvalid_out,
  output logic [3:0] ext_index_out,
  output logic ext_wr_out,
  output logic [7:0] ext_wdata_out,
  input wire logic [7:0] ext_rdata_in,
  input wire logic mem_wr_in,
  input wire logic mem_rd_in,
  input wire logic [19:0] mem_addr_in,
  input wire logic [7:0] mem_wdata_in,
  output logic [7:0] mem_rdata_out,
  output logic mem_rvalid_out,
  input wire logic chain_four_in,
  input wire logic [3:0] plane_write_enable_in,
  output pgd_pkg::pgd_plane_req_t plane_req_out,
  input wire logic [31:0] plane_rd_data_in,
  output pgd_pkg::pgd_load_t load_mode_out,
  output logic upper_from_select_out,
  output logic graphics_mode_out
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] rotr(input logic [7:0] b,
                                      input logic [2:0] n);
    logic [15:0] d;
    d = {b, b} >> n;
    return d[7:0];
  endfunction

  function automatic logic [7:0] wmask(input logic [3:0] idx);
    case (idx)
      pgd_pkg::PGD_R_ROT: return pgd_pkg::PGD_WM_ROT;
      pgd_pkg::PGD_R_RSEL: return pgd_pkg::PGD_WM_RSEL;
      pgd_pkg::PGD_R_MODE: return pgd_pkg::PGD_WM_MODE;
      pgd_pkg::PGD_R_MASK: return pgd_pkg::PGD_WM_FULL;
      default: return pgd_pkg::PGD_WM_NIBBLE;
    endcase
  endfunction

  // {hit, offset}
  function automatic logic [17:0] win_decode(input logic [1:0] map,
                                             input logic [19:0] a);
    logic hit;
    logic [19:0] d;
    hit = 1'b0;
    d = a - pgd_pkg::PGD_BASE_A000;
    case (map)
      pgd_pkg::PGD_WIN_128K: begin
        hit = a >= pgd_pkg::PGD_BASE_A000 && a < pgd_pkg::PGD_END_B800;
      end
      pgd_pkg::PGD_WIN_64K: begin
        hit = a >= pgd_pkg::PGD_BASE_A000 && a < pgd_pkg::PGD_END_A000;
      end
      pgd_pkg::PGD_WIN_B000: begin
        hit = a >= pgd_pkg::PGD_BASE_B000 && a < pgd_pkg::PGD_BASE_B800;
        d = a - pgd_pkg::PGD_BASE_B000;
      end
      default: begin
        hit = a >= pgd_pkg::PGD_BASE_B800 && a < pgd_pkg::PGD_END_B800;
        d = a - pgd_pkg::PGD_BASE_B800;
      end
    endcase
    return {hit, d[16:0]};
  endfunction

  function automatic logic [7:0] cmp_byte(input logic [31:0] planes,
                                          input logic [3:0] colour,
                                          input logic [3:0] care);
    logic [7:0] r;
    r = 8'hFF;
    for (int p = 0; p < 4; p++) begin
      r = r & ~({8{care[p]}} & (planes[p*8 +: 8] ^ {8{colour[p]}}));
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // state and decode
  // ---------------------------------------------------------------
  pgd_pkg::pgd_state_t s_reg;
  pgd_pkg::pgd_state_t s_next;

  logic [7:0] fill_v;
  logic [7:0] fill_en_v;
  logic [7:0] colour_v;
  logic [7:0] rot_v;
  logic [7:0] rsel_v;
  logic [7:0] mode_v;
  logic [7:0] misc_v;
  logic [7:0] care_v;
  logic [7:0] bmask_v;
  logic [1:0] wmode;
  logic [1:0] fn;
  logic [17:0] win;
  logic win_hit;
  logic [16:0] win_off;
  logic addr_oe;
  logic plane_oe;
  logic wr_take;
  logic rd_take;
  logic [7:0] rot_data;
  logic [15:0] mem_addr;

  assign fill_v = s_reg.regs[pgd_pkg::PGD_R_FILL];
  assign fill_en_v = s_reg.regs[pgd_pkg::PGD_R_FILL_EN];
  assign colour_v = s_reg.regs[pgd_pkg::PGD_R_CMP];
  assign rot_v = s_reg.regs[pgd_pkg::PGD_R_ROT];
  assign rsel_v = s_reg.regs[pgd_pkg::PGD_R_RSEL];
  assign mode_v = s_reg.regs[pgd_pkg::PGD_R_MODE];
  assign misc_v = s_reg.regs[pgd_pkg::PGD_R_MISC];
  assign care_v = s_reg.regs[pgd_pkg::PGD_R_CARE];
  assign bmask_v = s_reg.regs[pgd_pkg::PGD_R_MASK];
  assign wmode = mode_v[pgd_pkg::PGD_MODE_WM_LSB +: 2];
  assign fn = rot_v[pgd_pkg::PGD_FN_LSB +: 2];
  assign win = win_decode(misc_v[pgd_pkg::PGD_MISC_MAP_LSB +: 2],
                          mem_addr_in);
  assign win_hit = win[17];
  assign win_off = win[16:0];
  assign addr_oe = misc_v[pgd_pkg::PGD_MISC_OE];
  assign plane_oe = addr_oe |
                    (mode_v[pgd_pkg::PGD_MODE_OE] & ~chain_four_in);
  // out-of-window cycles belong to another device: ignored silently
  assign wr_take = mem_wr_in & win_hit;
  assign rd_take = mem_rd_in & win_hit;
  assign rot_data = rotr(mem_wdata_in, rot_v[pgd_pkg::PGD_ROT_LSB +: 3]);
  // high bit takes the place of address bit 0
  assign mem_addr = addr_oe ?
                    {win_off[15:1], win_off[pgd_pkg::PGD_WIN_HI_BIT]} :
                    win_off[15:0];

  always_comb begin
    logic [7:0] src;
    logic [7:0] alu;
    logic [7:0] lat;
    logic [7:0] msk;
    logic [3:0] sel_en;
    logic [1:0] plane;
    src = 8'h00;
    alu = 8'h00;
    lat = 8'h00;
    msk = 8'h00;
    sel_en = 4'hF;
    plane = 2'h0;
    s_next = s_reg;
    s_next.io_rvalid = 1'b0;
    s_next.mem_rvalid = 1'b0;
    s_next.ext_wr = 1'b0;
    s_next.req.wr = 1'b0;
    s_next.req.rd = 1'b0;

    if (io_wr_in && io_addr_in == pgd_pkg::PGD_INDEX_PORT) begin
      s_next.index = io_wdata_in[3:0];
    end
    // data port reaches the indexed register
    if (io_wr_in && io_addr_in == pgd_pkg::PGD_DATA_PORT) begin
      if (s_reg.index <= pgd_pkg::PGD_R_LAST) begin
        s_next.regs[s_reg.index] = io_wdata_in & wmask(s_reg.index);
      end else begin
        s_next.ext_wr = 1'b1;
        s_next.ext_wdata = io_wdata_in;
      end
    end
    if (io_rd_in && io_addr_in == pgd_pkg::PGD_INDEX_PORT) begin
      s_next.io_rvalid = 1'b1;
      s_next.io_rdata = {4'h0, s_reg.index};
    end
    if (io_rd_in && io_addr_in == pgd_pkg::PGD_DATA_PORT) begin
      s_next.io_rvalid = 1'b1;
      // indices above the set go to extensions
      if (s_reg.index <= pgd_pkg::PGD_R_LAST) begin
        s_next.io_rdata = s_reg.regs[s_reg.index];
      end else begin
        s_next.io_rdata = ext_rdata_in;
      end
    end

    // read issue: plane memory answers in the following cycle
    if (rd_take) begin
      s_next.req.rd = 1'b1;
      s_next.req.en = 4'h0;
      s_next.req.addr = mem_addr;
      s_next.rd_cmp = mode_v[pgd_pkg::PGD_MODE_RTYPE];
      // plane within chained pair picked by address bit 0
      s_next.rd_plane = plane_oe ? {rsel_v[1], mem_addr_in[0]} :
                                   rsel_v[1:0];
    end
    if (s_reg.req.rd) begin
      // every read reloads all four latches
      s_next.latch = plane_rd_data_in;
      s_next.mem_rvalid = 1'b1;
      plane = s_reg.rd_plane;
      if (s_reg.rd_cmp) begin
        s_next.mem_rdata = cmp_byte(plane_rd_data_in, colour_v[3:0],
                                    care_v[3:0]);
      end else begin
        s_next.mem_rdata = plane_rd_data_in[plane*8 +: 8];
      end
    end

    if (wr_take) begin
      s_next.req.wr = 1'b1;
      s_next.req.addr = mem_addr;
      // even addresses to 0/2, odd to 1/3
      if (plane_oe) begin
        sel_en = mem_addr_in[0] ? pgd_pkg::PGD_PLANES_ODD :
                                  pgd_pkg::PGD_PLANES_EVEN;
      end
      s_next.req.en = sel_en & plane_write_enable_in;
      // mode 3 mask is rotated data AND mask
      msk = (wmode == pgd_pkg::PGD_WMODE3) ? (rot_data & bmask_v) :
                                             bmask_v;
      for (int p = 0; p < 4; p++) begin
        lat = s_reg.latch[p*8 +: 8];
        case (wmode)
          pgd_pkg::PGD_WMODE0: src = fill_en_v[p] ? {8{fill_v[p]}} :
                                                    rot_data;
          pgd_pkg::PGD_WMODE2: src = {8{mem_wdata_in[p]}};
          pgd_pkg::PGD_WMODE3: src = {8{fill_v[p]}};
          default: src = lat;
        endcase
        case (fn)
          pgd_pkg::PGD_FN_AND: alu = src & lat;
          pgd_pkg::PGD_FN_OR: alu = src | lat;
          pgd_pkg::PGD_FN_XOR: alu = src ^ lat;
          default: alu = src;
        endcase
        if (wmode == pgd_pkg::PGD_WMODE1) begin
          s_next.req.data[p*8 +: 8] = lat;
        end else begin
          // mask merges new data with latches
          s_next.req.data[p*8 +: 8] = (alu & msk) | (lat & ~msk);
        end
      end
    end

    if (s_next.regs[pgd_pkg::PGD_R_MODE][pgd_pkg::PGD_MODE_256]) begin
      s_next.load_mode = pgd_pkg::PGD_LOAD_256;
    end else if (s_next.regs[pgd_pkg::PGD_R_MODE]
                 [pgd_pkg::PGD_MODE_SHIFT]) begin
      s_next.load_mode = pgd_pkg::PGD_LOAD_CGA;
    end else begin
      s_next.load_mode = pgd_pkg::PGD_LOAD_PLANAR;
    end
    // upper video bits from colour select
    s_next.upper_from_select =
      ~s_next.regs[pgd_pkg::PGD_R_MODE][pgd_pkg::PGD_MODE_256];
    s_next.graphics_mode =
      s_next.regs[pgd_pkg::PGD_R_MISC][pgd_pkg::PGD_MISC_GFX];
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign io_rdata_out = s_reg.io_rdata;
  assign io_rvalid_out = s_reg.io_rvalid;
  assign ext_index_out = s_reg.index;
  assign ext_wr_out = s_reg.ext_wr;
  assign ext_wdata_out = s_reg.ext_wdata;
  assign mem_rdata_out = s_reg.mem_rdata;
  assign mem_rvalid_out = s_reg.mem_rvalid;
  assign plane_req_out = s_reg.req;
  assign load_mode_out = s_reg.load_mode;
  assign upper_from_select_out = s_reg.upper_from_select;
  assign graphics_mode_out = s_reg.graphics_mode;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);

  sequence s_plain_wr(logic [1:0] m);
    wr_take && wmode == m && bmask_v == 8'hFF && fn == pgd_pkg::PGD_FN_PASS;
  endsequence

  chk_fill_mode0: assert property (
    s_plain_wr(pgd_pkg::PGD_WMODE0) ##0 fill_en_v[0] |=>
      plane_req_out.wr && plane_req_out.data[7:0] == {8{$past(fill_v[0])}})
    else $error("mode 0 fill byte wrong");

  chk_rotated_mode0: assert property (
    s_plain_wr(pgd_pkg::PGD_WMODE0) ##0 !fill_en_v[0] |=>
      plane_req_out.data[7:0] ==
      rotr($past(mem_wdata_in), $past(rot_v[2:0])))
    else $error("mode 0 rotated byte wrong");

  chk_compare_read: assert property (
    rd_take && mode_v[pgd_pkg::PGD_MODE_RTYPE] |=> plane_req_out.rd ##1
      mem_rvalid_out && mem_rdata_out == cmp_byte($past(plane_rd_data_in),
      $past(colour_v[3:0]), $past(care_v[3:0])))
    else $error("compare read result wrong");

  chk_no_care_all_ones: assert property (
    rd_take && mode_v[pgd_pkg::PGD_MODE_RTYPE] && care_v[3:0] == 4'h0
      ##1 care_v[3:0] == 4'h0 |=> mem_rdata_out == 8'hFF)
    else $error("excluded planes did not match");

  chk_plane_read: assert property (
    rd_take && !mode_v[pgd_pkg::PGD_MODE_RTYPE] && !plane_oe &&
      rsel_v[1:0] == 2'h2 ##1 1'b1 |=>
      mem_rdata_out == $past(plane_rd_data_in[23:16]))
    else $error("selected plane read wrong");

  chk_xor_function: assert property (
    wr_take && wmode == pgd_pkg::PGD_WMODE2 && bmask_v == 8'hFF &&
      fn == pgd_pkg::PGD_FN_XOR |=> plane_req_out.data[15:8] ==
      ({8{$past(mem_wdata_in[1])}} ^ $past(s_reg.latch[15:8])))
    else $error("xor function wrong");

  chk_latch_copy: assert property (
    wr_take && wmode == pgd_pkg::PGD_WMODE1 |=>
      plane_req_out.data == $past(s_reg.latch))
    else $error("mode 1 did not copy latches");

  chk_mode3_mask: assert property (
    wr_take && wmode == pgd_pkg::PGD_WMODE3 && fn == pgd_pkg::PGD_FN_PASS
      && !fill_v[3] |=> plane_req_out.data[31:24] ==
      ($past(s_reg.latch[31:24]) & ~($past(rot_data) & $past(bmask_v))))
    else $error("mode 3 mask wrong");

  chk_mask_keeps: assert property (
    wr_take && wmode != pgd_pkg::PGD_WMODE3 && bmask_v == 8'h00 |=>
      plane_req_out.data == $past(s_reg.latch))
    else $error("masked bits changed");

  chk_odd_even_planes: assert property (
    wr_take && plane_oe && mem_addr_in[0] |=>
      (plane_req_out.en & pgd_pkg::PGD_PLANES_EVEN) == 4'h0)
    else $error("odd address reached even plane");

  chk_window_miss: assert property (
    mem_wr_in && !win_hit && !mem_rd_in |=> !plane_req_out.wr)
    else $error("write outside window taken");

  chk_reg_readback: assert property (
    io_wr_in && io_addr_in == pgd_pkg::PGD_DATA_PORT &&
      s_reg.index == pgd_pkg::PGD_R_MASK ##1
      io_rd_in && io_addr_in == pgd_pkg::PGD_DATA_PORT && !io_wr_in |=>
      io_rvalid_out && io_rdata_out == $past(io_wdata_in, 2))
    else $error("bit mask readback wrong");

  chk_reset_clear: assert property (
    @(posedge clk_in) disable iff (1'b0)
      srst_in |=> s_reg.latch == 32'h0 && s_reg.regs == '0)
    else $error("reset left state");

endmodule // pgd_datapath

// ---- hw/pgd_pkg.sv ----
// constants, types and register layout of the planar graphics datapath
// Notes on behaviour
// - mode 0 enabled planes write replicated fill bit
// - mode 0 other planes take rotated, combined data
// - compare read returns ones where planes match
// - participation bit 0 makes plane always match
// - read type 0 returns selected plane byte
// - selector picks plane, chained pairs in odd/even
// - selector ignored during compare reads
// - function passes, ANDs, ORs or XORs latches
// - rotate host byte right by count
// - mode 1 writes latches; reads load latches
// - mode 2 replicates host bits per plane
// - mode 3 fill always, mask rotated AND mask
// - mask 0 keeps latch, 1 takes new
// - 256-colour bit picks shift load format
// - shift bit picks planar or CGA-style load
// - mode odd/even steers planes unless chain-four; misc odd/even steers them always
// - window field decodes host address range
// - misc odd/even replaces address bit 0
// - misc bit 0 selects graphics mode
// - index selects register, extension beyond set
// - registers read/write through data port
package pgd_pkg;

  // ---------------------------------------------------------------
  // ports and register indices
  // ---------------------------------------------------------------
  localparam logic [15:0] PGD_INDEX_PORT = 16'h03CE;
  localparam logic [15:0] PGD_DATA_PORT = 16'h03CF;
  localparam logic [3:0] PGD_R_FILL = 4'h0;
  localparam logic [3:0] PGD_R_FILL_EN = 4'h1;
  localparam logic [3:0] PGD_R_CMP = 4'h2;
  localparam logic [3:0] PGD_R_ROT = 4'h3;
  localparam logic [3:0] PGD_R_RSEL = 4'h4;
  localparam logic [3:0] PGD_R_MODE = 4'h5;
  localparam logic [3:0] PGD_R_MISC = 4'h6;
  localparam logic [3:0] PGD_R_CARE = 4'h7;
  localparam logic [3:0] PGD_R_MASK = 4'h8;
  localparam logic [3:0] PGD_R_LAST = 4'h8;
  localparam int PGD_NREGS = 9;

  // writable bits; reserved bits are stored as zero
  localparam logic [7:0] PGD_WM_NIBBLE = 8'h0F;
  localparam logic [7:0] PGD_WM_ROT = 8'h1F;
  localparam logic [7:0] PGD_WM_RSEL = 8'h03;
  localparam logic [7:0] PGD_WM_MODE = 8'h7B;
  localparam logic [7:0] PGD_WM_FULL = 8'hFF;

  // ---------------------------------------------------------------
  // field positions and codes
  // ---------------------------------------------------------------
  localparam int PGD_ROT_LSB = 0;
  localparam int PGD_FN_LSB = 3;
  localparam int PGD_MODE_WM_LSB = 0;
  localparam int PGD_MODE_RTYPE = 3;
  localparam int PGD_MODE_OE = 4;
  localparam int PGD_MODE_SHIFT = 5;
  localparam int PGD_MODE_256 = 6;
  localparam int PGD_MISC_GFX = 0;
  localparam int PGD_MISC_OE = 1;
  localparam int PGD_MISC_MAP_LSB = 2;
  localparam int PGD_WIN_HI_BIT = 16;
  localparam logic [1:0] PGD_FN_PASS = 2'h0;
  localparam logic [1:0] PGD_FN_AND = 2'h1;
  localparam logic [1:0] PGD_FN_OR = 2'h2;
  localparam logic [1:0] PGD_FN_XOR = 2'h3;
  localparam logic [1:0] PGD_WMODE0 = 2'h0;
  localparam logic [1:0] PGD_WMODE1 = 2'h1;
  localparam logic [1:0] PGD_WMODE2 = 2'h2;
  localparam logic [1:0] PGD_WMODE3 = 2'h3;
  localparam logic [1:0] PGD_WIN_128K = 2'h0;
  localparam logic [1:0] PGD_WIN_64K = 2'h1;
  localparam logic [1:0] PGD_WIN_B000 = 2'h2;
  localparam logic [1:0] PGD_WIN_B800 = 2'h3;
  localparam logic [19:0] PGD_BASE_A000 = 20'hA0000;
  localparam logic [19:0] PGD_BASE_B000 = 20'hB0000;
  localparam logic [19:0] PGD_BASE_B800 = 20'hB8000;
  localparam logic [19:0] PGD_END_A000 = 20'hB0000;
  localparam logic [19:0] PGD_END_B800 = 20'hC0000;
  localparam logic [3:0] PGD_PLANES_EVEN = 4'h5;
  localparam logic [3:0] PGD_PLANES_ODD = 4'hA;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PGD_LOAD_PLANAR,
    PGD_LOAD_CGA,
    PGD_LOAD_256
  } pgd_load_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [3:0] en;
    logic [31:0] data;
  } pgd_plane_req_t;

  typedef struct packed {
    logic [PGD_NREGS-1:0][7:0] regs;
    logic [3:0] index;
    logic [31:0] latch;
    logic rd_cmp;
    logic [1:0] rd_plane;
    pgd_plane_req_t req;
    logic [7:0] io_rdata;
    logic io_rvalid;
    logic [7:0] mem_rdata;
    logic mem_rvalid;
    logic ext_wr;
    logic [7:0] ext_wdata;
    pgd_load_t load_mode;
    logic upper_from_select;
    logic graphics_mode;
  } pgd_state_t;

endpackage
